// file: include/dpt_consts.svh
/*
 Constants for the dual prescaled down timer: register offsets, field
 positions, reset values and timing counts. Assumes an 8-bit data space.
*/
`ifndef DPT_CONSTS_SVH
`define DPT_CONSTS_SVH

`define DPT_ADDR_PRESCALER_1 8'hD2
`define DPT_ADDR_COUNT_1 8'hD3
`define DPT_ADDR_CONTROL_1 8'hD4
`define DPT_ADDR_PRESCALER_2 8'hDA
`define DPT_ADDR_COUNT_2 8'hDB
`define DPT_ADDR_CONTROL_2 8'hDC

`define DPT_BIT_ZERO_FLAG 7
`define DPT_BIT_IRQ_ENABLE 6
`define DPT_BIT_MODE 5
`define DPT_BIT_ON 4
`define DPT_BIT_RUN 3

`define DPT_RESET_COUNT 8'hFF
`define DPT_RESET_PRESCALER 7'h7F
`define DPT_RESET_CONTROL 8'h00

`define DPT_OSC_DIVIDE 12
`define DPT_VECTOR_TIMER_1 3'h3
`define DPT_VECTOR_TIMER_2 3'h2

`endif

// file: include/dpt_pkg.sv
/*
 Types shared by the dual prescaled down timer files.
 Assumes dpt_consts.svh supplies the numeric constants.
*/
package dpt_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic wr;
        logic rd;
    } dpt_bus_req_t;

    typedef struct packed {
        logic zero_reached_flag;
        logic zero_irq_enable;
        logic prescaler_run;
        logic [2:0] tap_select;
    } dpt_ctrl_t;
endpackage

// file: src/dpt_tick_gen.sv
/*
 Divide-by-twelve tick source for the prescalers.
 Assumes one system clock; emits a one-cycle pulse every twelve cycles.
*/
`timescale 1ns/100ps
`include "dpt_consts.svh"
module dpt_tick_gen import dpt_pkg::*; #(
    parameter int DIVIDE = `DPT_OSC_DIVIDE
) (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    output logic tick_o
);
    logic [3:0] count;
    wire logic at_end = (count == 4'(DIVIDE - 1));

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            count <= 4'h0;
            tick_o <= 1'b0;
        end else begin
            count <= at_end ? 4'h0 : count + 4'h1;
            tick_o <= at_end;
        end
    end
endmodule // dpt_tick_gen

// file: src/dpt_timer_unit.sv
/*
 One timer channel: 7-bit down prescaler, tap select, 8-bit down counter
 and the zero flag. Assumes software writes arrive as one-cycle strobes.
*/
`timescale 1ns/100ps
`include "dpt_consts.svh"
module dpt_timer_unit import dpt_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic tick_i,
    input wire logic enable_i,
    input wire logic wr_prescaler_i,
    input wire logic wr_count_i,
    input wire logic wr_control_i,
    input wire logic [7:0] wdata_i,
    output logic [6:0] prescaler_o,
    output logic [7:0] count_o,
    output dpt_ctrl_t ctrl_o
);
    // Prescaler advances on the divided tick; a tap rising edge is a 0->1 bit
    wire logic running = enable_i && ctrl_o.prescaler_run;
    wire logic pre_step = running && tick_i;
    wire logic [6:0] next_prescaler = prescaler_o - 7'h01;
    // Down counter: bit n-1 rises when it goes from 0 to 1 on a decrement
    wire logic [6:0] rising = ~prescaler_o & next_prescaler;
    // Tap zero follows every step; padding keeps the index inside the vector
    wire logic [7:0] tap_rise = {rising, 1'b1};
    wire logic [2:0] sel = ctrl_o.tap_select;
    wire logic tap_edge = pre_step && tap_rise[sel];
    wire logic [7:0] next_count = count_o - 8'h01;
    wire logic dec_to_zero = tap_edge && (next_count == 8'h00) && !wr_count_i;
    wire logic write_zero = wr_count_i && (wdata_i == 8'h00);
    wire logic ctrl_set = wr_control_i && wdata_i[`DPT_BIT_ZERO_FLAG];

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            prescaler_o <= `DPT_RESET_PRESCALER;
        end else if (!ctrl_o.prescaler_run) begin
            prescaler_o <= `DPT_RESET_PRESCALER;
        end else if (wr_prescaler_i) begin
            prescaler_o <= wdata_i[6:0];
        end else if (pre_step) begin
            prescaler_o <= next_prescaler;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            count_o <= `DPT_RESET_COUNT;
        end else if (wr_count_i) begin
            count_o <= wdata_i;
        end else if (tap_edge) begin
            count_o <= next_count;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            ctrl_o <= '0;
        end else begin
            if (wr_control_i) begin
                ctrl_o.zero_irq_enable <= wdata_i[`DPT_BIT_IRQ_ENABLE];
                ctrl_o.prescaler_run <= wdata_i[`DPT_BIT_RUN];
                ctrl_o.tap_select <= wdata_i[2:0];
            end
            // Hardware set beats a software clear in the same cycle
            if (dec_to_zero || write_zero || ctrl_set) begin
                ctrl_o.zero_reached_flag <= 1'b1;
            end else if (wr_control_i) begin
                ctrl_o.zero_reached_flag <= 1'b0;
            end
        end
    end
endmodule // dpt_timer_unit

// file: src/dpt_timer_top.sv
/*
 Dual prescaled down timer with its register port.
 Assumes a single-cycle strobe master; read data appear one cycle later.
 No interrupt controller here: requests leave as levels with vectors.
*/
`timescale 1ns/100ps
`include "dpt_consts.svh"
module dpt_timer_top import dpt_pkg::*; (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [7:0] rdata_o,
    output logic irq_timer_1_o,
    output logic irq_timer_2_o,
    output logic [2:0] vector_timer_1_o,
    output logic [2:0] vector_timer_2_o,
    output logic wake_o
);
    dpt_bus_req_t req;
    assign req = '{addr: addr_i, wdata: wdata_i, wr: wr_i, rd: rd_i};

    logic timers_on_bit;
    logic timers_mode_bit;
    logic tick;
    logic [6:0] prescaler_state_1;
    logic [6:0] prescaler_state_2;
    logic [7:0] count_value_1;
    logic [7:0] count_value_2;
    dpt_ctrl_t ctrl_1;
    dpt_ctrl_t ctrl_2;

    wire logic wr_pre_1 = req.wr && (req.addr == `DPT_ADDR_PRESCALER_1);
    wire logic wr_cnt_1 = req.wr && (req.addr == `DPT_ADDR_COUNT_1);
    wire logic wr_ctl_1 = req.wr && (req.addr == `DPT_ADDR_CONTROL_1);
    wire logic wr_pre_2 = req.wr && (req.addr == `DPT_ADDR_PRESCALER_2);
    wire logic wr_cnt_2 = req.wr && (req.addr == `DPT_ADDR_COUNT_2);
    wire logic wr_ctl_2 = req.wr && (req.addr == `DPT_ADDR_CONTROL_2);
    // Reserved combination with the mode bit set keeps both timers idle
    wire logic timers_enabled = timers_on_bit && !timers_mode_bit;

    wire logic [7:0] ctl_view_1 = {ctrl_1.zero_reached_flag, ctrl_1.zero_irq_enable,
        timers_mode_bit, timers_on_bit, ctrl_1.prescaler_run, ctrl_1.tap_select};
    wire logic [7:0] ctl_view_2 = {ctrl_2.zero_reached_flag, ctrl_2.zero_irq_enable,
        2'b00, ctrl_2.prescaler_run, ctrl_2.tap_select};

    logic [7:0] read_mux;
    always_comb begin
        unique case (req.addr)
            `DPT_ADDR_PRESCALER_1: read_mux = {1'b0, prescaler_state_1};
            `DPT_ADDR_COUNT_1: read_mux = count_value_1;
            `DPT_ADDR_CONTROL_1: read_mux = ctl_view_1;
            `DPT_ADDR_PRESCALER_2: read_mux = {1'b0, prescaler_state_2};
            `DPT_ADDR_COUNT_2: read_mux = count_value_2;
            `DPT_ADDR_CONTROL_2: read_mux = ctl_view_2;
            default: read_mux = 8'h00;
        endcase
    end

    wire logic next_irq_1 = ctrl_1.zero_reached_flag && ctrl_1.zero_irq_enable;
    wire logic next_irq_2 = ctrl_2.zero_reached_flag && ctrl_2.zero_irq_enable;

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            timers_on_bit <= 1'b0;
            timers_mode_bit <= 1'b0;
        end else if (wr_ctl_1) begin
            timers_on_bit <= req.wdata[`DPT_BIT_ON];
            timers_mode_bit <= req.wdata[`DPT_BIT_MODE];
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (!rst_b_i) begin
            rdata_o <= 8'h00;
            irq_timer_1_o <= 1'b0;
            irq_timer_2_o <= 1'b0;
            vector_timer_1_o <= `DPT_VECTOR_TIMER_1;
            vector_timer_2_o <= `DPT_VECTOR_TIMER_2;
            wake_o <= 1'b0;
        end else begin
            rdata_o <= req.rd ? read_mux : 8'h00;
            irq_timer_1_o <= next_irq_1;
            irq_timer_2_o <= next_irq_2;
            vector_timer_1_o <= `DPT_VECTOR_TIMER_1;
            vector_timer_2_o <= `DPT_VECTOR_TIMER_2;
            wake_o <= next_irq_1 || next_irq_2;
        end
    end

    dpt_tick_gen i_dpt_tick_gen (
        .clk_sys_i(clk_sys_i),
        .rst_b_i(rst_b_i),
        .tick_o(tick)
    );

    // Both channels share one tick so their taps stay in step
    wire logic [1:0] wr_pre = {wr_pre_2, wr_pre_1};
    wire logic [1:0] wr_cnt = {wr_cnt_2, wr_cnt_1};
    wire logic [1:0] wr_ctl = {wr_ctl_2, wr_ctl_1};
    logic [6:0] pre_ch [2];
    logic [7:0] cnt_ch [2];
    dpt_ctrl_t ctrl_ch [2];

    for (genvar ch = 0; ch < 2; ch++) begin : g_timer
        dpt_timer_unit i_dpt_timer_unit (
            .clk_sys_i(clk_sys_i),
            .rst_b_i(rst_b_i),
            .tick_i(tick),
            .enable_i(timers_enabled),
            .wr_prescaler_i(wr_pre[ch]),
            .wr_count_i(wr_cnt[ch]),
            .wr_control_i(wr_ctl[ch]),
            .wdata_i(req.wdata),
            .prescaler_o(pre_ch[ch]),
            .count_o(cnt_ch[ch]),
            .ctrl_o(ctrl_ch[ch])
        );
    end

    assign prescaler_state_1 = pre_ch[0];
    assign prescaler_state_2 = pre_ch[1];
    assign count_value_1 = cnt_ch[0];
    assign count_value_2 = cnt_ch[1];
    assign ctrl_1 = ctrl_ch[0];
    assign ctrl_2 = ctrl_ch[1];
endmodule // dpt_timer_top

// file: bench/dpt_timer_monitor.sv
/*
 Port checker for dpt_timer_top.
 Assumes the bind after the module and the register map of the constants header.
*/
`timescale 1ns/100ps
module dpt_timer_monitor (
    input wire logic clk_sys_i,
    input wire logic rst_b_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic irq_timer_1_o,
    input wire logic irq_timer_2_o,
    input wire logic [2:0] vector_timer_1_o,
    input wire logic [2:0] vector_timer_2_o,
    input wire logic wake_o
);
    default clocking @(posedge clk_sys_i); endclocking
    default disable iff (!rst_b_i);
    // Read data and irq outputs register on one edge, so they must agree
    property p_irq1; rd_i && addr_i == 8'hD4 |=> irq_timer_1_o == (rdata_o[7] && rdata_o[6]);
    endproperty
    a_irq1: assert property (p_irq1) else $error("irq 1 mismatch");
    property p_irq2; rd_i && addr_i == 8'hDC |=> irq_timer_2_o == (rdata_o[7] && rdata_o[6]);
    endproperty
    a_irq2: assert property (p_irq2) else $error("irq 2 mismatch");
    property p_rd_idle; !$past(rd_i) |-> rdata_o == 8'h00; endproperty
    a_rd_idle: assert property (p_rd_idle) else $error("stray read data");
    property p_t2bits; rd_i && addr_i == 8'hDC |=> rdata_o[5:4] == 2'b00; endproperty
    a_t2bits: assert property (p_t2bits) else $error("control 2 bits 5:4 set");
    property p_flag_wr; wr_i && addr_i == 8'hDC && wdata_i[7:6] == 2'b11 |=> ##1 irq_timer_2_o;
    endproperty
    a_flag_wr: assert property (p_flag_wr) else $error("flag write no irq");
    property p_zero_wr;
        wr_i && addr_i == 8'hDB && wdata_i == 8'h00 ##1 !(wr_i && addr_i == 8'hDC)
            ##1 rd_i && addr_i == 8'hDC |=> rdata_o[7];
    endproperty
    a_zero_wr: assert property (p_zero_wr) else $error("zero write no flag");
    property p_vec; vector_timer_1_o == 3'h3 && vector_timer_2_o == 3'h2; endproperty
    a_vec: assert property (p_vec) else $error("vector wrong");
    property p_wake; wake_o == (irq_timer_1_o || irq_timer_2_o); endproperty
    a_wake: assert property (p_wake) else $error("no wake");
endmodule // dpt_timer_monitor

bind dpt_timer_top dpt_timer_monitor i_dpt_timer_monitor (.clk_sys_i, .rst_b_i, .addr_i,
    .wdata_i, .wr_i, .rd_i, .rdata_o, .irq_timer_1_o, .irq_timer_2_o, .vector_timer_1_o,
    .vector_timer_2_o, .wake_o);

// file: bench/test_dpt_timer_top.sv
/*
 Self-checking bench for dpt_timer_top.
 Assumes the bound monitor; ticks every 12 clocks after reset.
*/
`timescale 1ns/100ps
module test_dpt_timer_top;
    logic clk_sys_i = 1'b0;
    logic rst_b_i = 1'b0;
    logic [7:0] addr_i = 8'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic [7:0] rdata_o;
    logic irq_1;
    logic irq_2;
    logic wake;
    logic [7:0] got;
    int bad_count = 0;
    int checked = 0;
    int cyc = 0;
    int n;
    always #5 clk_sys_i = ~clk_sys_i;
    dpt_timer_top i_dpt_timer_top (.clk_sys_i, .rst_b_i, .addr_i, .wdata_i, .wr_i, .rd_i,
        .rdata_o, .irq_timer_1_o(irq_1), .irq_timer_2_o(irq_2), .vector_timer_1_o(),
        .vector_timer_2_o(), .wake_o(wake));
    task automatic end_sim();
        $display("checks %0d mismatches %0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk_sys_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            bad_count++;
            end_sim();
        end
    end
    task automatic chk(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    // Gap cycle after each strobe keeps a strobe from being driven twice in one step
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge clk_sys_i);
        wr_i <= 1'b0;
        @(posedge clk_sys_i);
    endtask
    task automatic rd(input logic [7:0] a);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge clk_sys_i);
        rd_i <= 1'b0;
        #1 got = rdata_o;
        @(posedge clk_sys_i);
    endtask
    task automatic wait_irq(input logic two);
        for (n = 0; n < 4000 && (two ? irq_2 : irq_1) !== 1'b1; n++) @(negedge clk_sys_i);
        @(posedge clk_sys_i);
    endtask
    task automatic t_reset();
        logic [7:0] a[7] = '{8'hD2, 8'hD3, 8'hD4, 8'hDA, 8'hDB, 8'hDC, 8'h00};
        logic [7:0] e[7] = '{8'h7F, 8'hFF, 8'h00, 8'h7F, 8'hFF, 8'h00, 8'h00};
        for (int i = 0; i < 7; i++) begin
            rd(a[i]);
            chk("reset value", got, e[i]);
        end
    endtask
    task automatic t_stopped();
        wr(8'hDA, 8'h10);
        rd(8'hDA);
        chk("held prescaler", got, 8'h7F);
        wr(8'hDC, 8'hFF);
        rd(8'hDC);
        chk("control 2", got, 8'hCF);
        wr(8'hDC, 8'h40);
        rd(8'hDC);
        chk("irq 2 cleared", {7'h0, irq_2}, 8'h00);
        wr(8'hDB, 8'h00);
        rd(8'hDC);
        chk("zero write flag", got, 8'hC0);
        wr(8'hD4, 8'h38);
        wr(8'hD3, 8'h05);
        repeat (30) @(posedge clk_sys_i);
        rd(8'hD3);
        chk("reserved mode count", got, 8'h05);
    endtask
    task automatic t_count();
        wr(8'hDC, 8'h00);
        wr(8'hD3, 8'h02);
        wr(8'hD4, 8'h58);
        wait_irq(1'b0);
        chk("irq 1", {7'h0, irq_1}, 8'h01);
        chk("wake", {7'h0, wake}, 8'h01);
        rd(8'hD3);
        chk("count at zero", got, 8'h00);
        repeat (10) @(posedge clk_sys_i);
        rd(8'hD3);
        chk("wrapped count", got, 8'hFF);
        wr(8'hD4, 8'h58);
        rd(8'hD4);
        chk("flag cleared by handler", got, 8'h58);
        chk("wake after clear", {7'h0, wake}, 8'h00);
    endtask
    // Timers held off while loading, so the delay starts at the enabling write
    task automatic t_taps();
        int lo;
        for (int t = 0; t < 8; t++) begin
            wr(8'hD4, 8'h00);
            wr(8'hDC, 8'h48 | 8'(t));
            wr(8'hDA, 8'h00);
            wr(8'hDB, 8'h02);
            wr(8'hD4, 8'h10);
            wait_irq(1'b1);
            lo = 12 << t;
            chk("tap delay", {7'h0, n >= lo + 2 && n <= lo + 13}, 8'h01);
        end
    endtask
    initial begin
        repeat (2) @(posedge clk_sys_i);
        rst_b_i <= 1'b1;
        @(posedge clk_sys_i);
        t_reset();
        t_stopped();
        t_count();
        t_taps();
        end_sim();
    end
endmodule // test_dpt_timer_top
